// [shared/ptbd_pkg.sv]
// Constants for the periodic tick and buzzer divider block
package ptbd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CTL_IDX = 8'h36;
  localparam logic [7:0] STS_IDX = 8'h37;
  localparam logic [7:0] CLR_IDX = 8'h38;
  localparam logic [7:0] ENA_IDX = 8'h39;

  // Control register fields
  localparam int         BUZ_EN_BIT   = 7;
  localparam int         BUZ_SEL_LSB  = 5;
  localparam int         ZERO_BIT     = 4;
  localparam int         TICK_EN_BIT  = 3;
  localparam int         TICK_SEL_LSB = 0;
  localparam logic [7:0] CTL_RESET    = 8'h00;

  // Interrupt bit layout shared by status, clear and enable
  localparam int         INT_TICK_BIT = 0;
  localparam int         NUM_INT      = 1;

  // Divider chain: bit k toggles every 2^k clocks, period 2^(k+1)
  localparam int         DIV_W        = 23;
  localparam int unsigned TICK_TAP [0:7] = '{22, 20, 15, 13, 12, 11, 10, 8};
  localparam int unsigned BUZ_TAP  [0:3] = '{12, 11, 10, 9};

endpackage

// [logic/ptbd_divider.sv]
// Free-running divider chain of the high frequency clock
`timescale 1ns/100ps
module ptbd_divider #(
  parameter int W = ptbd_pkg::DIV_W
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  output logic [W-1:0]      o_count
);

  if (W < 1) begin : g_bad_width
    $error("ptbd_divider: width must be at least one");
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_count <= '0;
    end else begin
      o_count <= o_count + 1'b1;
    end
  end

endmodule // ptbd_divider

// [logic/ptbd_top.sv]
// Periodic tick generator and buzzer divider with APB register access
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module ptbd_top #(
  parameter int ADDR_W = 12,
  parameter int DIV_W  = ptbd_pkg::DIV_W
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output logic                   o_irq,
  output logic                   o_tick_interrupt,
  output logic                   o_buzzer_out_pin_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (DIV_W < ptbd_pkg::DIV_W) begin : g_bad_div
    $error("ptbd_top: divider too short for the slowest tick tap");
  end
  if (ADDR_W < 10) begin : g_bad_addr
    $error("ptbd_top: address too narrow to reach the register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain

  logic [DIV_W-1:0] div_count;

  ptbd_divider #(
    .W (DIV_W)
  ) u_divider (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .o_count (div_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  localparam logic [ADDR_W-1:0] CTL_ADDR = ADDR_W'({ptbd_pkg::CTL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] STS_ADDR = ADDR_W'({ptbd_pkg::STS_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] CLR_ADDR = ADDR_W'({ptbd_pkg::CLR_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] ENA_ADDR = ADDR_W'({ptbd_pkg::ENA_IDX, 2'b00});

  logic        setup_ph;
  logic        access_done;
  logic        hit_ctl;
  logic        hit_sts;
  logic        hit_clr;
  logic        hit_ena;
  logic        hit_any;
  logic        wr_ctl;
  logic        wr_clr;
  logic        wr_ena;
  logic [7:0]  ctl_r;
  logic [ptbd_pkg::NUM_INT-1:0] sts_r;
  logic [ptbd_pkg::NUM_INT-1:0] ena_r;
  logic [7:0]  ctl_rdata;
  logic [31:0] rdata;

  assign setup_ph    = i_psel && !i_penable;
  // Access completes on the edge where the registered ready is seen high
  assign access_done = i_psel && i_penable && o_pready;
  assign hit_ctl     = (i_paddr == CTL_ADDR);
  assign hit_sts     = (i_paddr == STS_ADDR);
  assign hit_clr     = (i_paddr == CLR_ADDR);
  assign hit_ena     = (i_paddr == ENA_ADDR);
  assign hit_any     = hit_ctl || hit_sts || hit_clr || hit_ena;
  assign wr_ctl      = access_done && i_pwrite && hit_ctl;
  assign wr_clr      = access_done && i_pwrite && hit_clr;
  assign wr_ena      = access_done && i_pwrite && hit_ena;

  assign ctl_rdata = {ctl_r[7:5], 1'b0, ctl_r[3:0]};

  // Clear register is write only and reads as zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_ctl) begin
      rdata[7:0] = ctl_rdata;
    end else if (hit_sts) begin
      rdata[ptbd_pkg::NUM_INT-1:0] = sts_r;
    end else if (hit_ena) begin
      rdata[ptbd_pkg::NUM_INT-1:0] = ena_r;
    end
  end

  // One wait-free access phase: ready rises the cycle after setup
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= setup_ph;
      o_pslverr <= setup_ph && !hit_any;
      if (setup_ph && !i_pwrite) begin
        o_prdata <= rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic       tick_enable;
  logic [2:0] tick_rate_select;
  logic       buzzer_out_enable;
  logic [1:0] buzzer_rate_select;

  assign tick_enable        = ctl_r[ptbd_pkg::TICK_EN_BIT];
  assign tick_rate_select   = ctl_r[ptbd_pkg::TICK_SEL_LSB +: 3];
  assign buzzer_out_enable  = ctl_r[ptbd_pkg::BUZ_EN_BIT];
  assign buzzer_rate_select = ctl_r[ptbd_pkg::BUZ_SEL_LSB +: 2];

  // control register, zero at reset
  // Rate fields are stored as written; keeping them steady is software's duty
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctl_r <= ptbd_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      ctl_r <= {i_pwdata[7:5], 1'b0, i_pwdata[3:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick generation

  logic tick_tap;
  logic tick_tap_d_r;
  logic tick_en_d_r;
  logic tick_evt;

  assign tick_tap = div_count[ptbd_pkg::TICK_TAP[tick_rate_select]];

  // The delayed enable masks the cycle where the tap delay still holds the
  // old selection, so a combined rate and enable write cannot fire falsely
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tick_tap_d_r <= 1'b0;
      tick_en_d_r  <= 1'b0;
    end else begin
      tick_tap_d_r <= tick_tap;
      tick_en_d_r  <= tick_enable;
    end
  end

  assign tick_evt = tick_enable && tick_en_d_r && tick_tap_d_r && !tick_tap;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_tick_interrupt <= 1'b0;
    end else begin
      o_tick_interrupt <= tick_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and output

  logic [ptbd_pkg::NUM_INT-1:0] int_evt;

  assign int_evt[ptbd_pkg::INT_TICK_BIT] = tick_evt;

  // Sticky bits; a new event wins over a clear in the same cycle
  for (genvar b = 0; b < ptbd_pkg::NUM_INT; b++) begin : g_sts
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        sts_r[b] <= 1'b0;
      end else if (int_evt[b]) begin
        sts_r[b] <= 1'b1;
      end else if (wr_clr && i_pwdata[b]) begin
        sts_r[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ena_r <= '0;
    end else if (wr_ena) begin
      ena_r <= i_pwdata[ptbd_pkg::NUM_INT-1:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(sts_r & ena_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buzzer output

  logic buz_tap;

  assign buz_tap = div_count[ptbd_pkg::BUZ_TAP[buzzer_rate_select]];

  // enable gates pin
  // Pin is active low and idles high so the buzzer sees no drive when off
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_buzzer_out_pin_n <= 1'b1;
    end else begin
      o_buzzer_out_pin_n <= buzzer_out_enable ? !buz_tap : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_ctl_write;
    wr_ctl;
  endsequence

  sequence s_tap_fall_enabled;
    tick_enable && tick_en_d_r && $fell(tick_tap) && $stable(tick_rate_select);
  endsequence

  property p_ctl_reset;
    @(posedge i_mclk) !i_rst_n |=> (ctl_rdata == 8'h00);
  endproperty
  a_ctl_reset: assert property (p_ctl_reset)
    else $error("control register not zero after reset");

  property p_zero_bit;
    @(posedge i_mclk) disable iff (!i_rst_n)
      s_ctl_write |=> (ctl_rdata[ptbd_pkg::ZERO_BIT] == 1'b0)
                      && (ctl_r[3:0] == $past(i_pwdata[3:0]));
  endproperty
  a_zero_bit: assert property (p_zero_bit)
    else $error("control write stored wrongly or bit 4 not zero");

  property p_tick_tap;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (tick_rate_select == 3'h0) |-> (tick_tap == div_count[22]);
  endproperty
  a_tick_tap: assert property (p_tick_tap)
    else $error("slowest tick tap is not divider bit 22");

  property p_tick_fires;
    @(posedge i_mclk) disable iff (!i_rst_n)
      s_tap_fall_enabled |=> o_tick_interrupt;
  endproperty
  a_tick_fires: assert property (p_tick_fires)
    else $error("tick missed on falling tap edge");

  property p_tick_only_on_fall;
    @(posedge i_mclk) disable iff (!i_rst_n)
      o_tick_interrupt |-> $past(tick_enable) && $past(tick_tap_d_r) && !$past(tick_tap);
  endproperty
  a_tick_only_on_fall: assert property (p_tick_only_on_fall)
    else $error("tick raised without an enabled falling edge");

  property p_combined_write;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (s_ctl_write ##1 (tick_enable && !$past(tick_enable))) |-> !o_tick_interrupt ##1 !o_tick_interrupt;
  endproperty
  a_combined_write: assert property (p_combined_write)
    else $error("spurious tick right after enabling");

  property p_div_not_cleared;
    @(posedge i_mclk) disable iff (!i_rst_n)
      s_ctl_write ##1 1'b1 |-> (div_count == DIV_W'($past(div_count) + 1'b1));
  endproperty
  a_div_not_cleared: assert property (p_div_not_cleared)
    else $error("divider disturbed by control write");

  property p_div_counts;
    @(posedge i_mclk) disable iff (!i_rst_n)
      $past(i_rst_n) |-> (div_count == DIV_W'($past(div_count, 1) + 1'b1));
  endproperty
  a_div_counts: assert property (p_div_counts)
    else $error("divider did not advance by one");

  property p_buz_wave;
    @(posedge i_mclk) disable iff (!i_rst_n)
      buzzer_out_enable && (buzzer_rate_select == 2'h3) |=>
        (o_buzzer_out_pin_n == !$past(div_count[9]));
  endproperty
  a_buz_wave: assert property (p_buz_wave)
    else $error("buzzer pin does not follow its tap");

  property p_buz_tap;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (buzzer_rate_select == 2'h0) |-> (buz_tap == div_count[12]);
  endproperty
  a_buz_tap: assert property (p_buz_tap)
    else $error("buzzer tap for select zero is wrong");

  property p_buz_off;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !buzzer_out_enable [*2] |-> o_buzzer_out_pin_n;
  endproperty
  a_buz_off: assert property (p_buz_off)
    else $error("buzzer pin driven while disabled");

  property p_sts_set;
    @(posedge i_mclk) disable iff (!i_rst_n)
      tick_evt |=> sts_r[ptbd_pkg::INT_TICK_BIT];
  endproperty
  a_sts_set: assert property (p_sts_set)
    else $error("tick did not set its status bit");

  property p_sts_clear;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (wr_clr && i_pwdata[ptbd_pkg::INT_TICK_BIT] && !tick_evt) |=>
        !sts_r[ptbd_pkg::INT_TICK_BIT];
  endproperty
  a_sts_clear: assert property (p_sts_clear)
    else $error("status bit not cleared by a write of one");

  property p_irq_on;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (sts_r[ptbd_pkg::INT_TICK_BIT] && ena_r[ptbd_pkg::INT_TICK_BIT]) |=> o_irq;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("interrupt low although an enabled status bit is set");

  property p_irq_off;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !sts_r[ptbd_pkg::INT_TICK_BIT] |=> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt high with no status bit set");

  property p_tick_tap_mid;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (tick_rate_select == 3'h3) |-> (tick_tap == div_count[13]);
  endproperty
  a_tick_tap_mid: assert property (p_tick_tap_mid)
    else $error("tick tap for select three is not divider bit 13");

  property p_div_reset;
    @(posedge i_mclk) !i_rst_n |=> (div_count == '0);
  endproperty
  a_div_reset: assert property (p_div_reset)
    else $error("divider not zero after reset");

endmodule // ptbd_top

// [testbench/ptbd_partner.sv]
// Observer model of the interrupt controller and the piezo buzzer load
`timescale 1ns/100ps
module ptbd_partner (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_tick,
  input  wire logic i_buz_n,
  output int        o_tick_cnt,
  output int        o_tick_gap,
  output int        o_phase_cnt,
  output int        o_lo_len,
  output int        o_hi_len
);
  int   gap_r;
  int   run_r;
  logic prev_r;
  ////////////////////////////////////////////////////////////////
  // one accepted request per tick pulse, spacing kept for checks
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_tick_cnt <= 0;
      o_tick_gap <= 0;
      gap_r      <= 0;
    end else if (i_tick === 1'b1) begin
      o_tick_cnt <= o_tick_cnt + 1;
      o_tick_gap <= gap_r + 1;
      gap_r      <= 0;
    end else begin
      gap_r <= gap_r + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  // phase lengths of the drive; the first one after enable may be partial
  always_ff @(posedge i_mclk) begin
    prev_r <= i_buz_n;
    if (!i_rst_n) begin
      o_phase_cnt <= 0;
      run_r       <= 0;
    end else if (i_buz_n !== prev_r) begin
      o_phase_cnt <= o_phase_cnt + 1;
      run_r       <= 0;
      if (prev_r) o_hi_len <= run_r + 1;
      else o_lo_len <= run_r + 1;
    end else begin
      run_r <= run_r + 1;
    end
  end
endmodule // ptbd_partner

// [testbench/periodic_tick_and_buzzer_divider_tb.sv]
// Self-checking bench for the periodic tick and buzzer divider
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); end end
module periodic_tick_and_buzzer_divider_tb;
  localparam logic [11:0] A_CTL = {2'b00, ptbd_pkg::CTL_IDX, 2'b00};
  localparam logic [11:0] A_STS = {2'b00, ptbd_pkg::STS_IDX, 2'b00};
  localparam logic [11:0] A_CLR = {2'b00, ptbd_pkg::CLR_IDX, 2'b00};
  localparam logic [11:0] A_ENA = {2'b00, ptbd_pkg::ENA_IDX, 2'b00};
  logic        i_mclk, i_rst_n, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic        o_pready, o_pslverr, o_irq, o_tick_interrupt, o_buzzer_out_pin_n;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          error_cnt, samples_checked, tick_cnt, tick_gap, phase_cnt, lo_len, hi_len;

  ptbd_top #(.ADDR_W(12)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq),
    .o_tick_interrupt(o_tick_interrupt), .o_buzzer_out_pin_n(o_buzzer_out_pin_n));
  ptbd_partner u_partner (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tick(o_tick_interrupt),
    .i_buz_n(o_buzzer_out_pin_n), .o_tick_cnt(tick_cnt), .o_tick_gap(tick_gap),
    .o_phase_cnt(phase_cnt), .o_lo_len(lo_len), .o_hi_len(hi_len));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] ex);
    int k;
    @(posedge i_mclk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    exp_q.push_back({wr, err, ex});
    @(posedge i_mclk);
    i_penable <= 1'b1;
    k = 0;
    do begin @(posedge i_mclk); k++; end while (o_pready !== 1'b1 && k < 20);
    if (k >= 20) begin error_cnt++; $display("MISMATCH pready exp=1 got=0"); finish_test(); end
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'($urandom), d}, 1'b0, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] ex);
    apb(1'b0, a, 32'h0, 1'b0, {24'h0, ex});
  endtask
  task automatic wait_for(input logic ph, input int n, input int lim);
    int k;
    int c;
    c = ph ? phase_cnt : tick_cnt;
    k = 0;
    while ((ph ? phase_cnt : tick_cnt) < c + n && k < lim) begin @(posedge i_mclk); k++; end
    if (k >= lim) begin error_cnt++; $display("MISMATCH wait exp=1 got=0"); finish_test(); end
  endtask
  // Results are matched in issue order as each transfer completes
  always @(posedge i_mclk) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      e = exp_q.pop_front();
      `CHK("pslverr", e[32], o_pslverr)
      if (!e[33]) `CHK("prdata", e[31:0], o_prdata)
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    int per;
    int t0;
    logic [11:0] bad;
    {i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    error_cnt = 0;
    samples_checked = 0;
    t0 = $urandom(66);
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    `CHK("pin", 1'b1, o_buzzer_out_pin_n)
    rd(A_CTL, 8'h00);
    bad = 12'h400 + 12'(($urandom % 64) * 4);
    apb(1'b1, bad, $urandom, 1'b1, 32'h0);
    apb(1'b0, bad, 32'h0, 1'b1, 32'h0);
    wr(A_CTL, 8'h1F);
    rd(A_CTL, 8'h0F);
    wait_for(1'b0, 1, 520);
    repeat (3) @(posedge i_mclk);
    `CHK("irq", 1'b0, o_irq)
    rd(A_STS, 8'h01);
    wr(A_ENA, 8'h01);
    repeat (2) @(posedge i_mclk);
    `CHK("irq", 1'b1, o_irq)
    wr(A_CLR, 8'h01);
    repeat (2) @(posedge i_mclk);
    `CHK("irq", 1'b0, o_irq)
    rd(A_STS, 8'h00);
    wr(A_CTL, 8'h07);
    for (int s = 4; s < 8; s++) begin
      per = 1 << (ptbd_pkg::TICK_TAP[s] + 1);
      wr(A_CTL, 8'(8'h08 | s));
      // first tick may be early but never later than one period
      wait_for(1'b0, 1, per + 4);
      wait_for(1'b0, 1, per + 4);
      `CHK("tick_gap", per, tick_gap)
      wr(A_CTL, 8'(s));
      rd(A_CTL, 8'(s));
    end
    repeat (4) @(posedge i_mclk);
    t0 = tick_cnt;
    for (int r = 0; r < 4; r++) begin
      per = 1 << ptbd_pkg::BUZ_TAP[r];
      // Tick select follows r too, with the tick left disabled
      wr(A_CTL, 8'((r << 5) | r));
      wr(A_CTL, 8'(8'h80 | (r << 5) | r));
      rd(A_CTL, 8'(8'h80 | (r << 5) | r));
      wait_for(1'b1, 4, 5 * per + 10);
      `CHK("buz_low", per, lo_len)
      `CHK("buz_high", per, hi_len)
      wr(A_CTL, 8'((r << 5) | r));
      repeat (3) @(posedge i_mclk);
      `CHK("pin", 1'b1, o_buzzer_out_pin_n)
      per = phase_cnt;
      repeat (600) @(posedge i_mclk);
      `CHK("phases", per, phase_cnt)
    end
    `CHK("ticks", t0, tick_cnt)
    finish_test();
  end
endmodule // periodic_tick_and_buzzer_divider_tb
